/* File: hw/gpc_map.svh */
// register map, field positions and timing constants for the pin control block
// What this block does
// (RQ1) direction bit: 0 output, 1 input, reset input
// (RQ2) pull field: none, down, up, 11 reserved
// (RQ3) edge mode 0: single edge, reset value
// (RQ4) single edge: rising non-inverted, falling inverted
// (RQ5) edge mode 1: both edges, polarity ignored
// (RQ6) supply select: interface 0, always-on 1
// (RQ7) polarity: 0 inverted, 1 non-inverted, reset 1
// (RQ8) output type: 0 push-pull, 1 open-drain
// (RQ9) enable 0 tri-states pin, reset 0
// (RQ10) input codes 0/1: debounced or plain input
// (RQ11) input codes 2-6: power control requests
// (RQ12) input codes 7-9: watchdog, voltage-scale selects
// (RQ13) input codes 10-13: hardware enables and controls
// (RQ14) input codes 14/15: debounced hardware controls
// (RQ15) output codes 0/1: output value, 32k oscillator
// (RQ16) output codes 2-4: state indicators, 5-7 reserved
// (RQ17) output codes 8-11: scaling done, power enables
// (RQ18) output codes 12/13: supply good, power good
// (RQ19) output codes 14/15: 2MHz clock, auxiliary reset
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// register indices; byte address is four times the index
`define GPC_CTRL_IDX 30'h0000403F
`define GPC_STAT_IDX 30'h00004100
`define GPC_OUTV_IDX 30'h00004101

`define GPC_CTRL_RESET 16'hA400
`define GPC_CTRL_WMASK 16'hFE8F
`define GPC_OUTV_RESET 1'h0

`define GPC_DIR_BIT 15
`define GPC_PULL_HI 14
`define GPC_PULL_LO 13
`define GPC_MODE_BIT 12
`define GPC_DOM_BIT 11
`define GPC_POL_BIT 10
`define GPC_OD_BIT 9
`define GPC_ENA_BIT 7
`define GPC_FN_HI 3
`define GPC_FN_LO 0

`define GPC_PULL_NONE 2'h0
`define GPC_PULL_DOWN 2'h1
`define GPC_PULL_UP 2'h2

`define GPC_FN_IN_GPIO_DB 4'h0
`define GPC_FN_IN_GPIO 4'h1
`define GPC_FN_IN_PWR_ONOFF 4'h2
`define GPC_FN_IN_SLP_WAKE 4'h3
`define GPC_FN_IN_SLP_WAKE_DB 4'h4
`define GPC_FN_IN_SLEEP 4'h5
`define GPC_FN_IN_PWR_ON 4'h6
`define GPC_FN_IN_WDOG 4'h7
`define GPC_FN_IN_VOLTAGE_SCALE_SELECT_ONE 4'h8
`define GPC_FN_IN_VOLTAGE_SCALE_SELECT_TWO 4'h9
`define GPC_FN_IN_HWEN1 4'hA
`define GPC_FN_IN_HWEN2 4'hB
`define GPC_FN_IN_HWCTL1 4'hC
`define GPC_FN_IN_HWCTL2 4'hD
`define GPC_FN_IN_HWCTL1_DB 4'hE
`define GPC_FN_IN_HWCTL2_DB 4'hF

// long debounce time, not given; plain default
`define GPC_LONG_DB_US 1000
`define GPC_CLK_MHZ 100
`define GPC_LONG_DB_CYCLES (`GPC_LONG_DB_US * `GPC_CLK_MHZ)

`endif

/* File: hw/gpc_pkg.sv */
// types shared by the pin control block
`default_nettype none
package gpc_pkg;
	typedef logic [3:0] gpc_fn_t;
	typedef logic [1:0] gpc_pull_t;
	typedef struct packed {
		logic dir_in;
		gpc_pull_t pull;
		logic both_edges;
		logic dom_always_on;
		logic non_inverted;
		logic open_drain;
		logic rsvd8;
		logic enable;
		logic [2:0] rsvd6_4;
		gpc_fn_t fn;
	} gpc_ctrl_s;
endpackage
`default_nettype wire

/* File: hw/gpc_debounce.sv */
// optional long debounce filter for the synchronised pin level
`timescale 1ns/1ps
`default_nettype none
module gpc_debounce #(
	parameter int CYCLES = 100000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic long_en,
	input wire logic level_in,
	output logic level_out
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;
	logic stable;

	wire differs = level_in != stable;
	wire expired = count == LAST;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
			stable <= 1'b0;
		end else if (!long_en || (differs && expired)) begin
			count <= '0;
			stable <= level_in;
		end else if (differs) begin
			count <= count + CW'(1);
		end else begin
			count <= '0;
		end
	end

	// short path bypasses the filter entirely
	assign level_out = long_en ? stable : level_in;
endmodule // gpc_debounce
`default_nettype wire

/* File: hw/gpc_pin_control.sv */
// control logic of one general-purpose pin with its APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.svh"
module gpc_pin_control #(
	parameter int DEBOUNCE_CYCLES = `GPC_LONG_DB_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// pad
	input wire logic PIN_IN,
	output logic PIN_OUT,
	output logic PIN_OE,
	output logic PULL_UP_EN,
	output logic PULL_DOWN_EN,
	output logic SUPPLY_DOMAIN_SEL,
	// sources for output functions
	input wire logic OSC_32K,
	input wire logic STATE_ON,
	input wire logic STATE_SLEEP,
	input wire logic STATE_CHANGE,
	input wire logic VOLTAGE_SCALE_SELECT_ONE_DONE,
	input wire logic VOLTAGE_SCALE_SELECT_TWO_DONE,
	input wire logic EXT_PWR_EN1,
	input wire logic EXT_PWR_EN2,
	input wire logic SYSTEM_SUPPLY_GOOD,
	input wire logic CONVERTER_POWER_GOOD,
	input wire logic EXT_PWR_CLK_2M,
	input wire logic AUX_RESET,
	// input function results
	output logic GPIO_IN,
	output logic REQ_PWR_ONOFF,
	output logic REQ_SLEEP_WAKE,
	output logic REQ_SLEEP,
	output logic REQ_PWR_ON,
	output logic WDOG_RESET_IN,
	output logic VOLTAGE_SCALE_SELECT_ONE,
	output logic VOLTAGE_SCALE_SELECT_TWO,
	output logic HW_ENABLE1,
	output logic HW_ENABLE2,
	output logic HW_CONTROL1,
	output logic HW_CONTROL2,
	output logic PIN_EDGE_EVENT
);
	localparam int NFN = 16;

	// control register and its fields
	logic [15:0] ctrl;
	logic gpio_out_value;
	gpc_pkg::gpc_ctrl_s cfg;
	assign cfg = gpc_pkg::gpc_ctrl_s'(ctrl);

	wire pin_direction = ctrl[`GPC_DIR_BIT];
	wire irq_edge_mode = ctrl[`GPC_MODE_BIT];
	wire pin_polarity = ctrl[`GPC_POL_BIT];
	wire pin_enable = ctrl[`GPC_ENA_BIT];
	wire [3:0] pin_function = ctrl[`GPC_FN_HI:`GPC_FN_LO];

	// APB decode: word aligned, whole index compared
	wire aligned = PADDR[1:0] == 2'h0;
	wire [29:0] word_idx = PADDR[31:2];
	wire hit_ctrl = aligned && word_idx == `GPC_CTRL_IDX;
	wire hit_stat = aligned && word_idx == `GPC_STAT_IDX;
	wire hit_outv = aligned && word_idx == `GPC_OUTV_IDX;
	wire mapped = hit_ctrl || hit_stat || hit_outv;
	wire setup_ph = PSEL && !PENABLE;
	wire access_ph = PSEL && PENABLE;
	wire wr_commit = access_ph && PWRITE && mapped;

	// byte lanes 0 and 1 carry the control word
	wire [15:0] lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
	wire [15:0] wr_bits = lane_mask & `GPC_CTRL_WMASK;
	wire [15:0] next_ctrl = (ctrl & ~wr_bits) | (PWDATA[15:0] & wr_bits);

	// pin synchroniser
	logic pin_meta;
	logic pin_sync;
	// oscillator comes from its own crystal domain
	logic osc_meta;
	logic osc_sync;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
		end else begin
			pin_meta <= PIN_IN;
			pin_sync <= pin_meta;
			osc_meta <= OSC_32K;
			osc_sync <= osc_meta;
		end
	end

	// input mode is direction set; active input also needs the pin enabled
	wire in_mode = pin_direction; // RQ1
	wire in_active = in_mode && pin_enable; // RQ9

	// long debounce only for the four codes that ask for it
	wire fn_db = pin_function == `GPC_FN_IN_GPIO_DB; // RQ10
	wire fn_sw_db = pin_function == `GPC_FN_IN_SLP_WAKE_DB; // RQ11
	wire fn_hc_db = pin_function == `GPC_FN_IN_HWCTL1_DB ||
		pin_function == `GPC_FN_IN_HWCTL2_DB; // RQ14
	wire long_db = in_mode && (fn_db || fn_sw_db || fn_hc_db);

	logic pin_filtered;

	gpc_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_debounce (
		.clk(CLK_SYS),
		.rst(RST),
		.long_en(long_db),
		.level_in(pin_sync),
		.level_out(pin_filtered)
	);

	// logical level: inverted polarity reads a low pin as asserted
	wire in_level = pin_polarity ? pin_filtered : !pin_filtered; // RQ7

	// edge detection on the logical level
	logic level_prev;
	logic edge_event;
	wire rise = in_level && !level_prev;
	wire fall = !in_level && level_prev;
	// logical rise is a pin rise when non-inverted, a pin fall when inverted
	wire single_hit = !irq_edge_mode && rise; // RQ3 RQ4
	wire both_hit = irq_edge_mode && (rise || fall); // RQ5
	wire next_edge = in_active && (single_hit || both_hit);

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			level_prev <= 1'b0;
			edge_event <= 1'b0;
		end else begin
			level_prev <= in_level;
			edge_event <= next_edge;
		end
	end

	// input function decode, one hit per code
	logic [NFN-1:0] fn_hit;
	genvar gi;
	generate
		for (gi = 0; gi < NFN; gi++) begin : g_fn
			assign fn_hit[gi] = in_active && in_level &&
				pin_function == 4'(gi);
		end
	endgenerate

	wire next_gpio = fn_hit[`GPC_FN_IN_GPIO_DB] || fn_hit[`GPC_FN_IN_GPIO]; // RQ10
	wire next_onoff = fn_hit[`GPC_FN_IN_PWR_ONOFF]; // RQ11
	wire next_slpwk = fn_hit[`GPC_FN_IN_SLP_WAKE] ||
		fn_hit[`GPC_FN_IN_SLP_WAKE_DB]; // RQ11
	wire next_sleep = fn_hit[`GPC_FN_IN_SLEEP]; // RQ11
	wire next_pwron = fn_hit[`GPC_FN_IN_PWR_ON]; // RQ11
	wire next_wdog = fn_hit[`GPC_FN_IN_WDOG]; // RQ12
	wire next_voltage_scale_select_one = fn_hit[`GPC_FN_IN_VOLTAGE_SCALE_SELECT_ONE]; // RQ12
	wire next_voltage_scale_select_two = fn_hit[`GPC_FN_IN_VOLTAGE_SCALE_SELECT_TWO]; // RQ12
	wire next_hwen1 = fn_hit[`GPC_FN_IN_HWEN1]; // RQ13
	wire next_hwen2 = fn_hit[`GPC_FN_IN_HWEN2]; // RQ13
	wire next_hwc1 = fn_hit[`GPC_FN_IN_HWCTL1] ||
		fn_hit[`GPC_FN_IN_HWCTL1_DB]; // RQ13 RQ14
	wire next_hwc2 = fn_hit[`GPC_FN_IN_HWCTL2] ||
		fn_hit[`GPC_FN_IN_HWCTL2_DB]; // RQ13 RQ14

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			GPIO_IN <= 1'b0;
			REQ_PWR_ONOFF <= 1'b0;
			REQ_SLEEP_WAKE <= 1'b0;
			REQ_SLEEP <= 1'b0;
			REQ_PWR_ON <= 1'b0;
			WDOG_RESET_IN <= 1'b0;
			VOLTAGE_SCALE_SELECT_ONE <= 1'b0;
			VOLTAGE_SCALE_SELECT_TWO <= 1'b0;
			HW_ENABLE1 <= 1'b0;
			HW_ENABLE2 <= 1'b0;
			HW_CONTROL1 <= 1'b0;
			HW_CONTROL2 <= 1'b0;
		end else begin
			GPIO_IN <= next_gpio;
			REQ_PWR_ONOFF <= next_onoff;
			REQ_SLEEP_WAKE <= next_slpwk;
			REQ_SLEEP <= next_sleep;
			REQ_PWR_ON <= next_pwron;
			WDOG_RESET_IN <= next_wdog;
			VOLTAGE_SCALE_SELECT_ONE <= next_voltage_scale_select_one;
			VOLTAGE_SCALE_SELECT_TWO <= next_voltage_scale_select_two;
			HW_ENABLE1 <= next_hwen1;
			HW_ENABLE2 <= next_hwen2;
			HW_CONTROL1 <= next_hwc1;
			HW_CONTROL2 <= next_hwc2;
		end
	end

	// output function sources, indexed by function code
	wire [NFN-1:0] out_src = {
		AUX_RESET, // RQ19
		EXT_PWR_CLK_2M, // RQ19
		CONVERTER_POWER_GOOD, // RQ18
		SYSTEM_SUPPLY_GOOD, // RQ18
		EXT_PWR_EN2, // RQ17
		EXT_PWR_EN1, // RQ17
		VOLTAGE_SCALE_SELECT_TWO_DONE, // RQ17
		VOLTAGE_SCALE_SELECT_ONE_DONE, // RQ17
		3'h0, // RQ16
		STATE_CHANGE, // RQ16
		STATE_SLEEP, // RQ16
		STATE_ON, // RQ16
		osc_sync, // RQ15
		gpio_out_value // RQ15
	};
	wire out_logical = out_src[pin_function];
	// reserved codes drive the inactive level, not a raw zero on the pad
	wire next_pin_level = pin_polarity ? out_logical : !out_logical; // RQ7

	// pad flops load what ctrl becomes at this same edge, but the pin level from ctrl as it was,
	// so drive, pulls and supply switch with the register while the pin level lags a ctrl write by a cycle
	wire ctrl_load = wr_commit && hit_ctrl;
	wire [15:0] ctrl_after = ctrl_load ? next_ctrl : ctrl;
	wire drive_after = !ctrl_after[`GPC_DIR_BIT] && ctrl_after[`GPC_ENA_BIT]; // RQ1 RQ9
	wire od_after = ctrl_after[`GPC_OD_BIT];
	wire [1:0] pull_after = ctrl_after[`GPC_PULL_HI:`GPC_PULL_LO];
	// reset word, so the pad flops start where ctrl does
	wire [15:0] ctrl_start = `GPC_CTRL_RESET;
	wire [1:0] pull_start = ctrl_start[`GPC_PULL_HI:`GPC_PULL_LO];

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PIN_OUT <= 1'b0;
			PIN_OE <= 1'b0;
			PULL_UP_EN <= pull_start == `GPC_PULL_UP;
			PULL_DOWN_EN <= pull_start == `GPC_PULL_DOWN;
			SUPPLY_DOMAIN_SEL <= ctrl_start[`GPC_DOM_BIT];
		end else begin
			// open drain only pulls low; high is released to the pull or outside
			PIN_OUT <= !od_after && next_pin_level; // RQ8
			PIN_OE <= drive_after && (!od_after || !next_pin_level); // RQ8 RQ9
			// reserved pull code enables neither resistor
			PULL_UP_EN <= pull_after == `GPC_PULL_UP; // RQ2
			PULL_DOWN_EN <= pull_after == `GPC_PULL_DOWN; // RQ2
			SUPPLY_DOMAIN_SEL <= ctrl_after[`GPC_DOM_BIT]; // RQ6
		end
	end
	assign PIN_EDGE_EVENT = edge_event;

	// register writes commit in the access phase
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ctrl <= `GPC_CTRL_RESET; // RQ1 RQ2 RQ3 RQ6 RQ7 RQ8 RQ9 RQ10
		end else if (wr_commit && hit_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			gpio_out_value <= `GPC_OUTV_RESET;
		end else if (wr_commit && hit_outv && PSTRB[0]) begin
			gpio_out_value <= PWDATA[0];
		end
	end

	// status: raw pin, filtered pin, logical level, driving
	wire [31:0] stat_word = {
		28'h0,
		PIN_OE,
		in_level,
		pin_filtered,
		pin_sync
	};
	wire [31:0] rd_word = hit_ctrl ? {16'h0, cfg} :
		hit_stat ? stat_word :
		hit_outv ? {31'h0, gpio_out_value} :
		32'h0;

	// read data captured in setup so it comes from a flop in access
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PRDATA <= 32'h0;
		end else if (setup_ph) begin
			PRDATA <= PWRITE ? 32'h0 : rd_word;
		end
	end

	assign PREADY = 1'b1;
	// unmapped or misaligned access answers with an error, nothing written
	assign PSLVERR = access_ph && !mapped;
endmodule // gpc_pin_control
`default_nettype wire

/* File: verif/gpc_pin_control_properties.sv */
// port checker of the pin control block
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_control_properties (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic PIN_OUT,
	input wire logic PIN_OE,
	input wire logic PULL_UP_EN,
	input wire logic PULL_DOWN_EN,
	input wire logic SUPPLY_DOMAIN_SEL
);
	wire acc = PSEL & PENABLE;
	wire wr = acc & PWRITE & (PADDR == 32'h000100FC);
	wire hi = wr & PSTRB[1];
	wire hit = PADDR inside {32'h000100FC, 32'h00010400, 32'h00010404};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_pull_decode: assert property (hi |=> {PULL_UP_EN, PULL_DOWN_EN} ==
		($past(PWDATA[14:13]) == 2'h3 ? 2'h0 : $past(PWDATA[14:13]))) else $error("bad pull");
	a_supply_sel: assert property (hi |=> SUPPLY_DOMAIN_SEL == $past(PWDATA[11]))
		else $error("bad supply select");
	a_input_quiet: assert property (hi & PWDATA[15] |=> !PIN_OE)
		else $error("input pin drives");
	a_tristate_off: assert property (wr & PSTRB[0] & !PWDATA[7] |=> !PIN_OE [*2])
		else $error("disabled pin drives");
	a_od_low_only: assert property (hi & PWDATA[9] |=> !PIN_OUT)
		else $error("open drain drives high");
	a_zero_wait: assert property (acc |-> PREADY)
		else $error("access not ready");
	a_unmapped_err: assert property (acc |-> PSLVERR == !hit)
		else $error("bad slave error");
	a_reset_pads: assert property ($fell(RST) |-> PULL_DOWN_EN && !PULL_UP_EN &&
		!PIN_OE && !SUPPLY_DOMAIN_SEL) else $error("bad pad reset state");
endmodule // gpc_pin_control_properties
bind gpc_pin_control gpc_pin_control_properties chk_i (
	.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULL_UP_EN(PULL_UP_EN),
	.PULL_DOWN_EN(PULL_DOWN_EN), .SUPPLY_DOMAIN_SEL(SUPPLY_DOMAIN_SEL)
);
`default_nettype wire

/* File: verif/gpc_pad_model.sv */
// far-side circuitry: external driver, pulls, floating pad
`timescale 1ns/1ps
`default_nettype none
module gpc_pad_model (
	input wire logic clk,
	input wire logic oe,
	input wire logic dout,
	input wire logic pu,
	input wire logic pd,
	input wire logic ext_en,
	input wire logic ext_val,
	output logic pad
);
	logic last = 1'h0;
	// a floating pad toggles, so no stale level can pass
	assign pad = oe ? dout : ext_en ? ext_val : pu ? 1'h1 : pd ? 1'h0 : ~last;
	always @(posedge clk) last <= pad;
endmodule // gpc_pad_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench of the pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] ca = 32'h000100FC;
	localparam logic [31:0] oa = 32'h00010404;
	logic clk, rst, psel, pen, pwr, pready, pslverr, er, pad, pin_out, pin_oe, pu, pd, dom, ev;
	logic ext_en, ext_val;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] src;
	wire [11:0] fo;
	int compares, miscompares;
	gpc_pin_control #(.DEBOUNCE_CYCLES(4)) dut (
		.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PIN_IN(pad), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd),
		.SUPPLY_DOMAIN_SEL(dom), .OSC_32K(src[1]), .STATE_ON(src[2]), .STATE_SLEEP(src[3]),
		.STATE_CHANGE(src[4]), .VOLTAGE_SCALE_SELECT_ONE_DONE(src[8]), .VOLTAGE_SCALE_SELECT_TWO_DONE(src[9]), .EXT_PWR_EN1(src[10]),
		.EXT_PWR_EN2(src[11]), .SYSTEM_SUPPLY_GOOD(src[12]), .CONVERTER_POWER_GOOD(src[13]),
		.EXT_PWR_CLK_2M(src[14]), .AUX_RESET(src[15]), .GPIO_IN(fo[11]), .REQ_PWR_ONOFF(fo[10]),
		.REQ_SLEEP_WAKE(fo[9]), .REQ_SLEEP(fo[8]), .REQ_PWR_ON(fo[7]), .WDOG_RESET_IN(fo[6]),
		.VOLTAGE_SCALE_SELECT_ONE(fo[5]), .VOLTAGE_SCALE_SELECT_TWO(fo[4]), .HW_ENABLE1(fo[3]),
		.HW_ENABLE2(fo[2]), .HW_CONTROL1(fo[1]), .HW_CONTROL2(fo[0]), .PIN_EDGE_EVENT(ev)
	);
	gpc_pad_model far (.clk(clk), .oe(pin_oe), .dout(pin_out), .pu(pu), .pd(pd),
		.ext_en(ext_en), .ext_val(ext_val), .pad(pad));
	always #5 clk = ~clk;
	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
		chk(n < 50, 1'h1);
		if (n >= 50) results;
	endtask
	task automatic wc(input logic [31:0] d);
		apb(1'h1, ca, d);
	endtask
	task automatic t_regs;
		apb(1'h0, ca, 32'h0);
		chk(rd, 32'h0000A400);
		chk({pin_oe, pu, pd, dom}, 4'h2);
		wc(32'hFFFFFFFF);
		apb(1'h0, ca, 32'h0);
		chk(rd, 32'h0000FE8F);
		apb(1'h0, 32'h00010408, 32'h0);
		chk(er, 1'h1);
		chk(rd, 32'h0);
		for (int p = 0; p < 4; p++) begin
			wc(32'h8000 | (p << 13) | (p << 11));
			chk({pu, pd, dom}, {p == 2, p == 1, p[0]});
		end
		$display("registers done");
	endtask
	task automatic t_infn;
		logic [11:0] e;
		for (int f = 0; f < 16; f++) begin
			e = 12'h800 >> (f < 2 ? 0 : f < 4 ? f - 1 : f < 14 ? f - 2 : f - 4);
			ext_val <= 1'h0;
			wc(16'hA480 | f);
			// long enough for sync and the shortened debounce
			cyc(20);
			chk(fo, 12'h0);
			ext_val <= 1'h1;
			cyc(20);
			chk(fo, e);
		end
		$display("input functions done");
	endtask
	task automatic t_edges;
		int n;
		for (int c = 0; c < 4; c++) begin
			ext_val <= 1'h0;
			wc(16'hA081 | (c[0] << 10) | (c[1] << 12));
			// config change may pulse by itself, so let it pass
			cyc(20);
			for (int v = 1; v >= 0; v--) begin
				ext_val <= v[0];
				n = 0;
				repeat (20) begin
					@(posedge clk);
					if (ev === 1'h1) n++;
				end
				chk(n, c[1] || c[0] == v[0]);
				chk(fo[11], v[0] ^ !c[0]);
			end
		end
		$display("edges done");
	endtask
	task automatic t_out;
		ext_en <= 1'h0;
		for (int f = 0; f < 16; f++) begin
			wc(16'h2480 | f);
			for (int v = 0; v < 2; v++) begin
				src <= v ? 16'h1 << f : ~(16'h1 << f);
				apb(1'h1, oa, v ^ (f != 0));
				cyc(10);
				chk({pin_oe, pin_out}, {1'h1, v == 1 && (f < 5 || f > 7)});
			end
		end
		for (int i = 0; i < 4; i++) begin
			wc(i == 0 ? 16'h2080 : i == 3 ? 16'h2400 : 16'h2680);
			apb(1'h1, oa, i != 2);
			cyc(10);
			chk({pin_oe, pin_out & pin_oe}, {!i[0], 1'h0});
		end
		$display("outputs done");
	endtask
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		psel = 1'h0;
		pen = 1'h0;
		pwr = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		src = 16'h0;
		ext_en = 1'h1;
		ext_val = 1'h0;
		cyc(20);
		rst <= 1'h0;
		@(posedge clk);
		t_regs;
		t_infn;
		t_edges;
		t_out;
		results;
	end
endmodule // tb_top
`default_nettype wire
